// file: hw/pcsc_client.v
// Purpose: Client-side GMII/MII datapath and SGMII status of a PCS.
// Assumes: All inputs synchronous to core_clk; MAC samples on enable ticks.
// Notes:   Byte path serves gigabit, nibble path serves 10/100 in SGMII.
//
// Contract
// - Byte receive valid stays high from the first preamble byte to the last CRC byte.
// - Both receive paths raise their error output while passing a frame with errors.
// - Nibble receive gives 4-bit data with valid high from first to last nibble.
// - Collision is raised when a collision is seen while a frame is transmitted.
// - Carrier sense is raised whenever transmit or receive activity is seen.
// - In 1000BASE-X the gigabit indication is 1 and the others are 0.
// - In SGMII, gigabit follows partner ability when negotiating, else forced speed 10.
// - In SGMII, 100 Mbps follows partner ability when negotiating, else forced speed 01.
// - In SGMII, 10 Mbps follows partner ability when negotiating, else forced speed 00.
// - In SGMII, half duplex follows partner ability when negotiating, else forced bit 1.
// - Receive and transmit client timing is supplied at the 125 MHz client rate.
// - In SGMII only, receive and transmit clock enables qualify the client clocks.
// - Receive and transmit logic each have their own active-high reset.
`timescale 1ns/100ps
`include "pcsc_defines.vh"

module pcsc_client (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        rx_reset,
   input  wire        tx_reset,
   input  wire        sgmii_mode,
   input  wire        negotiation_enable,
   input  wire [15:0] partner_ability,
   input  wire [1:0]  forced_speed,
   input  wire        forced_duplex,
   input  wire        pcs_rx_valid,
   input  wire [7:0]  pcs_rx_data,
   input  wire        pcs_rx_err,
   input  wire        pcs_col_det,
   input  wire [7:0]  mac_tx_byte,
   input  wire        mac_tx_byte_en,
   input  wire        mac_tx_byte_err,
   input  wire [3:0]  mac_tx_nib,
   input  wire        mac_tx_nib_en,
   input  wire        mac_tx_nib_err,
   output reg         byte_rx_valid,
   output reg  [7:0]  byte_rx_data,
   output reg         byte_rx_err,
   output wire        nibble_rx_valid,
   output wire [3:0]  nibble_rx_data,
   output wire        nibble_rx_err,
   output reg         pcs_tx_valid,
   output reg  [7:0]  pcs_tx_data,
   output reg         pcs_tx_err,
   output reg         col_ind,
   output reg         crs_ind,
   output reg         rx_clk_ena,
   output reg         tx_clk_ena,
   output reg         gig_ind,
   output reg         fast_ind,
   output reg         slow_ind,
   output reg         half_duplex_ind
);

   // ======================================================================
   // Speed decode
   function [2:0] spd_onehot;
      input [1:0] code;
      input [2:0] prev;
      begin
         case (code)
            `PCSC_SPD_1000: spd_onehot = `PCSC_OH_1000;
            `PCSC_SPD_100:  spd_onehot = `PCSC_OH_100;
            `PCSC_SPD_10:   spd_onehot = `PCSC_OH_10;
            default:        spd_onehot = prev;
         endcase
      end
   endfunction

   wire [2:0] spd_prev = {gig_ind, fast_ind, slow_ind};
   wire [1:0] pa_spd   = partner_ability[`PCSC_PA_SPD_HI:`PCSC_PA_SPD_LO];
   reg  [2:0] spd_d;
   reg        hd_d;

   always @* begin
      if (!sgmii_mode) begin
         spd_d = `PCSC_OH_1000;
         hd_d  = 1'b0;
      end else if (negotiation_enable) begin
         spd_d = spd_onehot(pa_spd, spd_prev);
         hd_d  = ~partner_ability[`PCSC_PA_DUPLEX];
      end else begin
         spd_d = spd_onehot(forced_speed, spd_prev);
         hd_d  = forced_duplex;
      end
   end

   // Reserved code holds the previous speed, keeping one hot
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gig_ind         <= 1'b1;
         fast_ind        <= 1'b0;
         slow_ind        <= 1'b0;
         half_duplex_ind <= 1'b0;
      end else begin
         gig_ind         <= spd_d[2];
         fast_ind        <= spd_d[1];
         slow_ind        <= spd_d[0];
         half_duplex_ind <= hd_d;
      end
   end

   wire nib_mode = sgmii_mode & ~gig_ind;

   // ======================================================================
   // Clock enables
   reg [6:0] rx_cnt_q;
   reg [6:0] tx_cnt_q;
   reg [6:0] div_d;

   always @* begin
      if (!nib_mode)
         div_d = `PCSC_DIV_ONE;
      else if (fast_ind)
         div_d = `PCSC_DIV_100;
      else
         div_d = `PCSC_DIV_10;
   end

   // Enables run at the 125 MHz client rate, divided for 10/100
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_cnt_q   <= 7'h0;
         rx_clk_ena <= 1'b1;
      end else if (rx_reset) begin
         rx_cnt_q   <= 7'h0;
         rx_clk_ena <= 1'b1;
      end else if (rx_cnt_q + `PCSC_DIV_ONE >= div_d) begin
         rx_cnt_q   <= 7'h0;
         rx_clk_ena <= 1'b1;
      end else begin
         rx_cnt_q   <= rx_cnt_q + `PCSC_DIV_ONE;
         rx_clk_ena <= 1'b0;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_cnt_q   <= 7'h0;
         tx_clk_ena <= 1'b1;
      end else if (tx_reset) begin
         tx_cnt_q   <= 7'h0;
         tx_clk_ena <= 1'b1;
      end else if (tx_cnt_q + `PCSC_DIV_ONE >= div_d) begin
         tx_cnt_q   <= 7'h0;
         tx_clk_ena <= 1'b1;
      end else begin
         tx_cnt_q   <= tx_cnt_q + `PCSC_DIV_ONE;
         tx_clk_ena <= 1'b0;
      end
   end

   // ======================================================================
   // Byte receive path
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         byte_rx_valid <= 1'b0;
         byte_rx_data  <= 8'h0;
         byte_rx_err   <= 1'b0;
      end else if (rx_reset || nib_mode) begin
         byte_rx_valid <= 1'b0;
         byte_rx_data  <= 8'h0;
         byte_rx_err   <= 1'b0;
      end else begin
         byte_rx_valid <= pcs_rx_valid;
         byte_rx_data  <= pcs_rx_valid ? pcs_rx_data : 8'h0;
         byte_rx_err   <= pcs_rx_valid & pcs_rx_err;
      end
   end

   // ======================================================================
   // Nibble receive path
   pcsc_nib_split u_split (
      .core_clk    (core_clk),
      .rst         (rst),
      .srst        (rx_reset | ~nib_mode),
      .tick        (rx_clk_ena),
      .in_valid    (pcs_rx_valid),
      .in_data     (pcs_rx_data),
      .in_err      (pcs_rx_err),
      .nib_valid_q (nibble_rx_valid),
      .nib_data_q  (nibble_rx_data),
      .nib_err_q   (nibble_rx_err)
   );

   // ======================================================================
   // Transmit path
   reg       tx_phase_q;
   reg [3:0] tx_lo_q;
   reg       tx_nerr_q;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_phase_q   <= 1'b0;
         tx_lo_q      <= 4'h0;
         tx_nerr_q    <= 1'b0;
         pcs_tx_valid <= 1'b0;
         pcs_tx_data  <= 8'h0;
         pcs_tx_err   <= 1'b0;
      end else if (tx_reset) begin
         tx_phase_q   <= 1'b0;
         tx_lo_q      <= 4'h0;
         tx_nerr_q    <= 1'b0;
         pcs_tx_valid <= 1'b0;
         pcs_tx_data  <= 8'h0;
         pcs_tx_err   <= 1'b0;
      end else if (!nib_mode) begin
         // Byte taken only while the MAC enable marks it valid
         tx_phase_q   <= 1'b0;
         tx_nerr_q    <= 1'b0;
         pcs_tx_valid <= mac_tx_byte_en;
         pcs_tx_data  <= mac_tx_byte_en ? mac_tx_byte : 8'h0;
         pcs_tx_err   <= mac_tx_byte_en & mac_tx_byte_err;
      end else begin
         pcs_tx_valid <= 1'b0;
         if (tx_clk_ena) begin
            if (!tx_phase_q) begin
               if (mac_tx_nib_en) begin
                  tx_lo_q    <= mac_tx_nib;
                  tx_nerr_q  <= mac_tx_nib_err;
                  tx_phase_q <= 1'b1;
               end
            end else begin
               // Odd trailing nibble goes out flagged as errored
               pcs_tx_valid <= 1'b1;
               pcs_tx_data  <= {mac_tx_nib_en ? mac_tx_nib : 4'h0, tx_lo_q};
               pcs_tx_err   <= tx_nerr_q | (mac_tx_nib_en ? mac_tx_nib_err : 1'b1);
               tx_phase_q   <= 1'b0;
            end
         end
      end
   end

   // ======================================================================
   // Collision and carrier sense
   wire tx_active = nib_mode ? (mac_tx_nib_en | tx_phase_q) : mac_tx_byte_en;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         col_ind <= 1'b0;
         crs_ind <= 1'b0;
      end else begin
         col_ind <= tx_active & (pcs_col_det | (half_duplex_ind & pcs_rx_valid));
         crs_ind <= tx_active | pcs_rx_valid;
      end
   end

endmodule // pcsc_client

// file: hw/pcsc_defines.vh
// Purpose: Shared constants of the PCS client-side GMII/MII block.
// Assumes: Included by every design file of the block.
// Notes:   Speed codes are shared by the forced field and partner ability.
`ifndef PCSC_DEFINES_VH
`define PCSC_DEFINES_VH

// ==========================================================================
// Speed encodings (forced speed field and partner ability speed bits)
`define PCSC_SPD_10          2'h0
`define PCSC_SPD_100         2'h1
`define PCSC_SPD_1000        2'h2
`define PCSC_SPD_RSVD        2'h3

// ==========================================================================
// Partner ability word layout
`define PCSC_PA_SPD_HI       11
`define PCSC_PA_SPD_LO       10
`define PCSC_PA_DUPLEX       12

// ==========================================================================
// One-hot speed vector positions {g, m100, m10}
`define PCSC_OH_1000         3'h4
`define PCSC_OH_100          3'h2
`define PCSC_OH_10           3'h1

// ==========================================================================
// Clock-enable divisors at the 125 MHz client rate
`define PCSC_DIV_100         7'hA
`define PCSC_DIV_10          7'h64
`define PCSC_DIV_ONE         7'h1

`endif

// file: hw/pcsc_nib_split.v
// Purpose: Splits receive bytes into low-then-high nibbles on enable ticks.
// Assumes: Source holds one byte across two ticks; sampled on the even tick.
// Notes:   Outputs hold between ticks, as the slow MII clock requires.
`timescale 1ns/100ps
`include "pcsc_defines.vh"

module pcsc_nib_split (
   input  wire       core_clk,
   input  wire       rst,
   input  wire       srst,
   input  wire       tick,
   input  wire       in_valid,
   input  wire [7:0] in_data,
   input  wire       in_err,
   output reg        nib_valid_q,
   output reg  [3:0] nib_data_q,
   output reg        nib_err_q
);

   reg       phase_q;
   reg [3:0] hi_q;
   reg       err_q;

   // ======================================================================
   // Nibble sequencing
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_q     <= 1'b0;
         hi_q        <= 4'h0;
         err_q       <= 1'b0;
         nib_valid_q <= 1'b0;
         nib_data_q  <= 4'h0;
         nib_err_q   <= 1'b0;
      end else if (srst) begin
         phase_q     <= 1'b0;
         hi_q        <= 4'h0;
         err_q       <= 1'b0;
         nib_valid_q <= 1'b0;
         nib_data_q  <= 4'h0;
         nib_err_q   <= 1'b0;
      end else if (tick) begin
         if (!phase_q) begin
            // Valid held through both nibbles of every byte
            nib_valid_q <= in_valid;
            nib_data_q  <= in_valid ? in_data[3:0] : 4'h0;
            nib_err_q   <= in_valid & in_err;
            hi_q        <= in_data[7:4];
            err_q       <= in_err;
            phase_q     <= in_valid;
         end else begin
            nib_data_q  <= hi_q;
            nib_err_q   <= err_q;
            phase_q     <= 1'b0;
         end
      end
   end

endmodule // pcsc_nib_split

// file: dv/pcsc_client_monitor.sv
// Purpose: Concurrent checks on the client-side PCS ports.
// Assumes: One core_clk domain; rst asynchronous, active high.
// Notes:   Bound to every pcsc_client instance.
`timescale 1ns/100ps
module pcsc_client_monitor (
   input logic        core_clk,
   input logic        rst,
   input logic        rx_reset,
   input logic        tx_reset,
   input logic        sgmii_mode,
   input logic        negotiation_enable,
   input logic [15:0] partner_ability,
   input logic [1:0]  forced_speed,
   input logic        forced_duplex,
   input logic        pcs_rx_valid,
   input logic        pcs_rx_err,
   input logic        mac_tx_byte_en,
   input logic        byte_rx_valid,
   input logic        byte_rx_err,
   input logic        pcs_tx_valid,
   input logic        col_ind,
   input logic        crs_ind,
   input logic        gig_ind,
   input logic        fast_ind,
   input logic        slow_ind,
   input logic        half_duplex_ind
);
   default clocking mon_cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ======================================================================
   // Byte path, plus collision implies carrier
   a_byte_rx_valid: assert property (gig_ind && !rx_reset |=> byte_rx_valid == $past(pcs_rx_valid))
      else $error("byte receive valid off");
   a_byte_rx_err: assert property (gig_ind && !rx_reset |=> byte_rx_err == ($past(pcs_rx_valid) && $past(pcs_rx_err)))
      else $error("byte receive error off");
   a_byte_tx_valid: assert property (gig_ind && !tx_reset |=> pcs_tx_valid == $past(mac_tx_byte_en))
      else $error("byte transmit valid off");
   a_col_has_crs: assert property (col_ind |-> crs_ind)
      else $error("collision without carrier");
   // ======================================================================
   // Status indications
   a_base_x_fixed: assert property (!sgmii_mode |=> gig_ind && !fast_ind && !slow_ind && !half_duplex_ind)
      else $error("base-x status wrong");
   a_speed_gig: assert property (sgmii_mode && (negotiation_enable ? partner_ability[11:10] : forced_speed) == 2'h2 |=> gig_ind && !fast_ind && !slow_ind)
      else $error("gigabit status wrong");
   a_speed_fast: assert property (sgmii_mode && (negotiation_enable ? partner_ability[11:10] : forced_speed) == 2'h1 |=> fast_ind && !gig_ind && !slow_ind)
      else $error("100M status wrong");
   a_speed_slow: assert property (sgmii_mode && (negotiation_enable ? partner_ability[11:10] : forced_speed) == 2'h0 |=> slow_ind && !gig_ind && !fast_ind)
      else $error("10M status wrong");
   a_duplex_forced: assert property (sgmii_mode && !negotiation_enable |=> half_duplex_ind == $past(forced_duplex))
      else $error("forced duplex wrong");
   a_duplex_neg: assert property (sgmii_mode && negotiation_enable |=> half_duplex_ind != $past(partner_ability[12]))
      else $error("negotiated duplex wrong");
   a_one_speed: assert property ($onehot({gig_ind, fast_ind, slow_ind}))
      else $error("speed not one-hot");
endmodule // pcsc_client_monitor

bind pcsc_client pcsc_client_monitor mon_u (.*);

// file: dv/pcsc_mac_model.sv
// Purpose: MAC transmit side facing the client interface.
// Assumes: Tasks are entered just after a core_clk edge.
// Notes:   Released data lines show the inverse of the last value.
`timescale 1ns/100ps
module pcsc_mac_model (
   input  wire       core_clk,
   input  wire       tx_clk_ena,
   output reg  [7:0] mac_tx_byte,
   output reg        mac_tx_byte_en,
   output reg        mac_tx_byte_err,
   output reg  [3:0] mac_tx_nib,
   output reg        mac_tx_nib_en,
   output reg        mac_tx_nib_err
);
   initial begin
      {mac_tx_byte, mac_tx_byte_en, mac_tx_byte_err} = 10'h000;
      {mac_tx_nib, mac_tx_nib_en, mac_tx_nib_err} = 6'h00;
   end
   task send_byte(input [7:0] d, input e);
      begin
         mac_tx_byte     <= d;
         mac_tx_byte_en  <= 1'h1;
         mac_tx_byte_err <= e;
         @(posedge core_clk);
      end
   endtask
   task end_byte;
      begin
         mac_tx_byte_en  <= 1'h0;
         mac_tx_byte_err <= 1'h0;
         mac_tx_byte     <= ~mac_tx_byte;
         @(posedge core_clk);
      end
   endtask
   // Held until an enable tick takes it
   task send_nib(input [3:0] d, input e);
      begin
         mac_tx_nib     <= d;
         mac_tx_nib_en  <= 1'h1;
         mac_tx_nib_err <= e;
         do @(posedge core_clk); while (tx_clk_ena !== 1'h1);
      end
   endtask
   task end_nib;
      begin
         mac_tx_nib_en  <= 1'h0;
         mac_tx_nib_err <= 1'h0;
         mac_tx_nib     <= ~mac_tx_nib;
      end
   endtask
endmodule // pcsc_mac_model

// file: dv/tb.sv
// Purpose: Self-checking bench of the client-side PCS block.
// Assumes: core_clk at 100 MHz; rst held 16 cycles.
// Notes:   Transmit traffic comes from the MAC model.
`timescale 1ns/100ps
module tb;
   logic        core_clk, rst, rx_reset, tx_reset, sgmii_mode, negotiation_enable;
   logic [15:0] partner_ability;
   logic [1:0]  forced_speed, sp;
   logic        forced_duplex, pcs_rx_valid, pcs_rx_err, pcs_col_det;
   logic [7:0]  pcs_rx_data, mac_tx_byte, byte_rx_data, pcs_tx_data;
   logic [3:0]  mac_tx_nib, nibble_rx_data;
   logic        mac_tx_byte_en, mac_tx_byte_err, mac_tx_nib_en, mac_tx_nib_err;
   logic        byte_rx_valid, byte_rx_err, nibble_rx_valid, nibble_rx_err, pcs_tx_valid;
   logic        pcs_tx_err, col_ind, crs_ind, rx_clk_ena, tx_clk_ena;
   logic        gig_ind, fast_ind, slow_ind, half_duplex_ind;
   integer      err_count, cmp_count, gap, i, n;

   pcsc_client    dut_u (.*);
   pcsc_mac_model mac_u (.*);

   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   // ======================================================================
   // Shared tasks
   task chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task settle;
      begin
         repeat (2) @(posedge core_clk);
         #1;
      end
   endtask
   // Returns at the edge that takes the receive tick; rx_clk_ena was raised at the edge before
   task wait_tick;
      begin
         gap = 0;
         do begin
            @(posedge core_clk);
            gap = gap + 1;
         end while (rx_clk_ena !== 1'h1 && gap < 300);
         if (gap >= 300) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: receive enable tick missing", $time);
         end
      end
   endtask
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // ======================================================================
   // Scenarios
   task t_status;
      begin
         @(posedge core_clk);
         sgmii_mode <= 1'h0;
         settle;
         chk({gig_ind, fast_ind, slow_ind, half_duplex_ind}, 8'h08);
         for (i = 0; i < 6; i = i + 1) begin
            sp = i % 3;
            @(posedge core_clk);
            sgmii_mode         <= 1'h1;
            negotiation_enable <= (i > 2);
            forced_speed       <= sp;
            forced_duplex      <= i[0];
            partner_ability    <= {3'h0, ~i[0], sp, 10'h000};
            settle;
            chk({gig_ind, fast_ind, slow_ind, half_duplex_ind}, {3'h1 << sp, i[0]});
         end
      end
   endtask
   task t_byte_rx;
      begin
         @(posedge core_clk);
         sgmii_mode <= 1'h0;
         settle;
         for (i = 0; i < 7; i = i + 1) begin
            @(posedge core_clk);
            pcs_rx_valid <= (i < 5);
            pcs_rx_data  <= 8'h50 + i[7:0];
            pcs_rx_err   <= (i == 2);
            #1;
            if (i > 0) begin
               chk({byte_rx_valid, byte_rx_err, crs_ind}, {i < 6, i == 3, i < 6});
               if (i < 6) chk(byte_rx_data, 8'h4F + i[7:0]);
            end
         end
         @(posedge core_clk);
         pcs_rx_valid <= 1'h1;
         rx_reset     <= 1'h1;
         settle;
         chk(byte_rx_valid, 8'h00);
         @(posedge core_clk);
         {rx_reset, pcs_rx_valid} <= 2'h0;
      end
   endtask
   task t_byte_tx;
      begin
         @(posedge core_clk);
         pcs_col_det <= 1'h1;
         mac_u.send_byte(8'hC1, 1'h0);
         #1;
         chk({pcs_tx_valid, pcs_tx_err, col_ind, crs_ind, pcs_tx_data[3:0]}, 8'hB1);
         mac_u.send_byte(8'hC2, 1'h1);
         #1;
         chk({pcs_tx_valid, pcs_tx_err, pcs_tx_data[5:0]}, 8'hC2);
         mac_u.end_byte;
         #1;
         chk(pcs_tx_valid, 8'h00);
         mac_u.send_byte(8'h3C, 1'h0);
         tx_reset <= 1'h1;
         @(posedge core_clk);
         #1;
         chk({pcs_tx_valid, tx_clk_ena}, 8'h01);
         mac_u.end_byte;
         tx_reset <= 1'h0;
         @(posedge core_clk);
         pcs_col_det <= 1'h0;
      end
   endtask
   task t_nibble;
      begin
         @(posedge core_clk);
         {sgmii_mode, negotiation_enable, forced_speed} <= 4'h9;
         repeat (3) wait_tick;
         chk(gap[7:0], 8'h0A);
         pcs_rx_valid <= 1'h1;
         pcs_rx_data  <= 8'hA5;
         pcs_rx_err   <= 1'h1;
         n = 0;
         for (i = 0; i < 7; i = i + 1) begin
            wait_tick;
            if (i == 3) {pcs_rx_valid, pcs_rx_err, pcs_rx_data} <= 10'h05A;
            #1;
            if (nibble_rx_valid === 1'h1) begin
               chk({nibble_rx_err, nibble_rx_data}, n[0] ? 8'h1A : 8'h15);
               n = n + 1;
            end
         end
         chk(n[7:0], 8'h04);
         wait_tick;
         mac_u.send_nib(4'h3, 1'h0);
         mac_u.send_nib(4'hC, 1'h1);
         mac_u.end_nib;
         n = 0;
         repeat (3) begin
            #1;
            if (pcs_tx_valid === 1'h1) begin
               chk({pcs_tx_err, pcs_tx_data[6:0]}, 8'hC3);
               n = n + 1;
            end
            @(posedge core_clk);
         end
         chk(n[7:0], 8'h01);
      end
   endtask
   // ======================================================================
   // Main sequence and watchdog
   initial begin
      {rst, rx_reset, tx_reset, sgmii_mode, negotiation_enable, forced_duplex} = 6'h20;
      {partner_ability, forced_speed, pcs_rx_data} = 26'h0;
      {pcs_rx_valid, pcs_rx_err, pcs_col_det} = 3'h0;
      err_count = 0;
      cmp_count = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'h0;
      t_status;
      t_byte_rx;
      t_byte_tx;
      t_nibble;
      complete_run;
   end
   initial begin
      #100000;
      err_count = err_count + 1;
      complete_run;
   end
endmodule // tb
